// File: verilog/dpram_pkg.sv
// Shared constants and types for the dual-port block RAM
package dpram_pkg;
   // -------------------------------------------------------
   // Array geometry
   // -------------------------------------------------------
   localparam int DATA_BITS = 16384;  // Data portion
   localparam int PAR_BITS  = 2048;   // Parity portion
   localparam int DMAX      = 32;     // Widest data bus
   localparam int PMAX      = 4;      // Widest parity bus
   localparam int AW        = 14;     // Widest address
   localparam int MULT_MAX_W = 18;    // Width cap with multiplier
   // Positions of the polarity bits in a port's INV vector
   localparam int INV_CLK = 0;
   localparam int INV_EN  = 1;
   localparam int INV_WE  = 2;
   localparam int INV_RST = 3;
   // Default output start and reset values
   localparam logic [35:0] OUT_ZERO = 36'h0_0000_0000;

   // Write modes of a port
   typedef enum logic [1:0] {
      WM_THROUGH    = 2'b00,
      WM_READ_FIRST = 2'b01,
      WM_HOLD       = 2'b10
   } write_mode_t;

   // Raw inputs of one port
   typedef struct packed {
      logic            en;
      logic            we;
      logic            rst;
      logic [AW-1:0]   addr;
      logic [DMAX-1:0] data;
      logic [PMAX-1:0] par;
   } port_in_t;

   // Decoded request of one port toward the array
   typedef struct packed {
      logic        en;
      logic        we;
      logic        rst;
      logic [14:0] doff;
      logic [11:0] poff;
      logic [31:0] dmask;
      logic [3:0]  pmask;
      logic [31:0] data;
      logic [3:0]  par;
   } port_req_t;

   // Data bits of a port width
   function automatic int dw_of(input int w);
      return (w >= 9) ? (w / 9) * 8 : w;
   endfunction : dw_of

   // Parity bits of a port width
   function automatic int pw_of(input int w);
      return (w >= 9) ? w / 9 : 0;
   endfunction : pw_of

   // Widths the array can serve
   function automatic bit legal_width(input int w);
      return (w == 1) || (w == 2) || (w == 4) ||
             (w == 9) || (w == 18) || (w == 36);
   endfunction : legal_width
endpackage : dpram_pkg

// File: verilog/dpram_port.sv
// One port: polarity, address decode and output register
`timescale 1ns/10ps
module dpram_port #(
   parameter int                      WIDTH     = 36,
   parameter dpram_pkg::write_mode_t  MODE      = dpram_pkg::WM_THROUGH,
   parameter logic [3:0]              INV       = 4'h0,
   parameter logic [35:0]             START_VAL = dpram_pkg::OUT_ZERO,
   parameter logic [35:0]             RESET_VAL = dpram_pkg::OUT_ZERO
) (
   input  logic                 clk,
   input  logic                 reset,
   input  dpram_pkg::port_in_t  pin,
   input  logic [31:0]          rd_data,
   input  logic [3:0]           rd_par,
   output dpram_pkg::port_req_t req,
   output logic [35:0]          dout_r
);
   // -------------------------------------------------------
   // Geometry of this port
   // -------------------------------------------------------
   // width set per instance
   localparam int DW    = dpram_pkg::dw_of(WIDTH);
   localparam int PW    = dpram_pkg::pw_of(WIDTH);
   localparam int LG    = $clog2(DW);
   localparam int PLG   = (PW > 1) ? $clog2(PW) : 0;
   localparam int ABITS = dpram_pkg::AW - LG;
   localparam logic [13:0] AMASK = 14'((32'h1 << ABITS) - 1);
   localparam logic [31:0] DMASK =
      (DW == 32) ? 32'hFFFF_FFFF : 32'((64'h1 << DW) - 1);
   localparam logic [3:0] PMASK = 4'((8'h1 << PW) - 1);

   dpram_pkg::port_in_t cap;     // Inputs at the active edge
   logic                en;      // Enable, polarity applied
   logic                we;      // Write enable, polarity applied
   logic                rst;     // Output reset, polarity applied
   logic [13:0]         addr_m;  // Address cut to port depth
   logic [35:0]         rd_word; // Stored word, masked
   logic [35:0]         wr_word; // Write word, masked
   logic [35:0]         load_val;
   logic [35:0]         dout_nxt;

   // -------------------------------------------------------
   // Clock polarity
   // -------------------------------------------------------
   // falling edge sampling
   generate
      if (INV[dpram_pkg::INV_CLK]) begin : g_fall
         dpram_pkg::port_in_t cap_r;
         // Capture on the falling edge, act on the next rise
         always_ff @(negedge clk) begin
            if (reset) cap_r <= '0;
            else       cap_r <= pin;
         end
         assign cap = cap_r;
      end else begin : g_rise
         assign cap = pin;
      end
   endgenerate

   assign en  = cap.en  ^ INV[dpram_pkg::INV_EN];
   assign we  = cap.we  ^ INV[dpram_pkg::INV_WE];
   assign rst = cap.rst ^ INV[dpram_pkg::INV_RST];

   // -------------------------------------------------------
   // Address decode
   // -------------------------------------------------------
   // low bits first slicing
   assign addr_m    = cap.addr & AMASK;
   assign req.en    = en;
   assign req.we    = we;
   assign req.rst   = rst;
   assign req.doff  = 15'(addr_m) << LG;
   assign req.poff  = (PW > 0) ? (12'(addr_m) << PLG) : 12'h000;
   assign req.dmask = DMASK;
   assign req.pmask = PMASK;
   assign req.data  = cap.data & DMASK;
   assign req.par   = cap.par & PMASK;

   // -------------------------------------------------------
   // Output register
   // -------------------------------------------------------
   assign rd_word = {rd_par & PMASK, rd_data & DMASK};
   assign wr_word = {req.par, req.data};
   assign load_val =
      rst                      ? RESET_VAL :
      !we                      ? rd_word   :
      (MODE == dpram_pkg::WM_THROUGH)    ? wr_word :
      (MODE == dpram_pkg::WM_READ_FIRST) ? rd_word :
      dout_r;
   assign dout_nxt = en ? load_val : dout_r;

   always_ff @(posedge clk) begin
      if (reset) dout_r <= START_VAL;
      else       dout_r <= dout_nxt;
   end
endmodule : dpram_port

// File: verilog/dual_port_block_ram.sv
// Dual-port 18 Kbit block RAM with per-port width
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// What this block does
// - Two synchronous ports share one 18 Kbit array
// - Each port width chosen on its own
// - Parity widths reach all 18 Kbit
// - Narrow widths reach only 16 Kbit data
// - Mixed: wide gets all, narrow data only
// - Widths 1,2,4,9,18,36 with matching addresses
// - Read edge loads stored word into output
// - Enabled write edge stores the data
// - Each write also reads, per write mode
// - Write-through copies write data to output
// - Read-first loads old contents to output
// - Hold mode keeps output during writes
// - Enable, write enable and output reset of each port have optional inversion; clock inversion moves only input capture to the falling edge; RESET has none
// - Disabled port does nothing on an edge
// - Enabled output reset loads reset value
// - Reset restores contents and start values
// - Start and reset values set per port
// - Inputs sampled at edge, outputs registered
module dual_port_block_ram #(
   parameter int                     WIDTH_A     = 36,
   parameter int                     WIDTH_B     = 36,
   parameter dpram_pkg::write_mode_t MODE_A      = dpram_pkg::WM_THROUGH,
   parameter dpram_pkg::write_mode_t MODE_B      = dpram_pkg::WM_THROUGH,
   parameter logic [3:0]             INV_A       = 4'h0,
   parameter logic [3:0]             INV_B       = 4'h0,
   parameter logic [35:0]            START_A     = dpram_pkg::OUT_ZERO,
   parameter logic [35:0]            START_B     = dpram_pkg::OUT_ZERO,
   parameter logic [35:0]            RESET_VAL_A = dpram_pkg::OUT_ZERO,
   parameter logic [35:0]            RESET_VAL_B = dpram_pkg::OUT_ZERO,
   parameter logic [16383:0]         MEMORY_CONTENTS_INIT = '0,
   parameter logic [2047:0]          PARITY_CONTENTS_INIT = '0,
   parameter bit                     MULT_IN_USE = 1'b0
) (
   input  logic        CLK,
   input  logic        RESET,
   input  logic        PORT_A_ENABLE,
   input  logic        PORT_A_WRITE_ENABLE,
   input  logic        SYNC_OUTPUT_RESET_A,
   input  logic [13:0] ADDR_A,
   input  logic [31:0] WRITE_DATA_IN_A,
   input  logic [3:0]  WRITE_PARITY_IN_A,
   output logic [31:0] READ_DATA_OUT_A,
   output logic [3:0]  READ_PARITY_OUT_A,
   input  logic        PORT_B_ENABLE,
   input  logic        PORT_B_WRITE_ENABLE,
   input  logic        SYNC_OUTPUT_RESET_B,
   input  logic [13:0] ADDR_B,
   input  logic [31:0] WRITE_DATA_IN_B,
   input  logic [3:0]  WRITE_PARITY_IN_B,
   output logic [31:0] READ_DATA_OUT_B,
   output logic [3:0]  READ_PARITY_OUT_B
);
   // -------------------------------------------------------
   // Configuration checks
   // -------------------------------------------------------
   // only documented widths
   generate
      if (!dpram_pkg::legal_width(WIDTH_A) ||
          !dpram_pkg::legal_width(WIDTH_B)) begin : g_bad_w
         $error("Port width not supported");
      end
      if (MULT_IN_USE && (WIDTH_A > dpram_pkg::MULT_MAX_W ||
          WIDTH_B > dpram_pkg::MULT_MAX_W)) begin : g_bad_m
         $error("Width above 18 while multiplier used");
      end
   endgenerate

   // -------------------------------------------------------
   // Storage
   // -------------------------------------------------------
   localparam int DTOP = dpram_pkg::DATA_BITS + dpram_pkg::DMAX;
   localparam int PTOP = dpram_pkg::PAR_BITS + dpram_pkg::PMAX;

   // Data and parity cells, padded so a slice never runs off
   logic [DTOP-1:0]        dmem_r;
   logic [PTOP-1:0]        pmem_r;

   dpram_pkg::port_in_t    pin_a;   // Port A bundle
   dpram_pkg::port_in_t    pin_b;   // Port B bundle
   dpram_pkg::port_req_t   req_a;   // Decoded port A
   dpram_pkg::port_req_t   req_b;   // Decoded port B
   logic [31:0]            rd_a;    // Stored data at A
   logic [3:0]             rp_a;    // Stored parity at A
   logic [31:0]            rd_b;    // Stored data at B
   logic [3:0]             rp_b;    // Stored parity at B
   logic [35:0]            dout_a;  // Output register A
   logic [35:0]            dout_b;  // Output register B
   logic                   wr_a;    // Port A writes
   logic                   wr_b;    // Port B writes

   // -------------------------------------------------------
   // Port bundles
   // -------------------------------------------------------
   // inputs bundled for edge sampling
   assign pin_a = '{en: PORT_A_ENABLE, we: PORT_A_WRITE_ENABLE,
                    rst: SYNC_OUTPUT_RESET_A, addr: ADDR_A,
                    data: WRITE_DATA_IN_A, par: WRITE_PARITY_IN_A};
   assign pin_b = '{en: PORT_B_ENABLE, we: PORT_B_WRITE_ENABLE,
                    rst: SYNC_OUTPUT_RESET_B, addr: ADDR_B,
                    data: WRITE_DATA_IN_B, par: WRITE_PARITY_IN_B};

   dpram_port #(
      .WIDTH     (WIDTH_A),
      .MODE      (MODE_A),
      .INV       (INV_A),
      .START_VAL (START_A),
      .RESET_VAL (RESET_VAL_A)
   ) u_port_a (
      .clk     (CLK),
      .reset   (RESET),
      .pin     (pin_a),
      .rd_data (rd_a),
      .rd_par  (rp_a),
      .req     (req_a),
      .dout_r  (dout_a)
   );

   dpram_port #(
      .WIDTH     (WIDTH_B),
      .MODE      (MODE_B),
      .INV       (INV_B),
      .START_VAL (START_B),
      .RESET_VAL (RESET_VAL_B)
   ) u_port_b (
      .clk     (CLK),
      .reset   (RESET),
      .pin     (pin_b),
      .rd_data (rd_b),
      .rd_par  (rp_b),
      .req     (req_b),
      .dout_r  (dout_b)
   );

   // -------------------------------------------------------
   // Read paths
   // -------------------------------------------------------
   // both ports read one array
   assign rd_a = dmem_r[req_a.doff +: 32];
   assign rp_a = pmem_r[req_a.poff +: 4];
   assign rd_b = dmem_r[req_b.doff +: 32];
   assign rp_b = pmem_r[req_b.poff +: 4];

   assign wr_a = req_a.en & req_a.we;
   assign wr_b = req_b.en & req_b.we;

   // -------------------------------------------------------
   // Array update
   // -------------------------------------------------------
   // masked bit writes per port
   // Bitwise so one port never clobbers the other's bits;
   // on a true collision the lower-offset port lands last, port B at equal offsets.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         dmem_r <= {{dpram_pkg::DMAX{1'b0}}, MEMORY_CONTENTS_INIT};
         pmem_r <= {{dpram_pkg::PMAX{1'b0}}, PARITY_CONTENTS_INIT};
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (wr_a && req_a.dmask[i])
               dmem_r[req_a.doff + 15'(i)] <= req_a.data[i];
            if (wr_b && req_b.dmask[i])
               dmem_r[req_b.doff + 15'(i)] <= req_b.data[i];
         end
         for (int j = 0; j < 4; j++) begin
            if (wr_a && req_a.pmask[j])
               pmem_r[req_a.poff + 12'(j)] <= req_a.par[j];
            if (wr_b && req_b.pmask[j])
               pmem_r[req_b.poff + 12'(j)] <= req_b.par[j];
         end
      end
   end

   // -------------------------------------------------------
   // Outputs
   // -------------------------------------------------------
   // outputs straight from registers
   assign READ_DATA_OUT_A   = dout_a[31:0];
   assign READ_PARITY_OUT_A = dout_a[35:32];
   assign READ_DATA_OUT_B   = dout_b[31:0];
   assign READ_PARITY_OUT_B = dout_b[35:32];

   // -------------------------------------------------------
   // Checks
   // -------------------------------------------------------
   // Previous-cycle view for the properties below
   dpram_pkg::port_req_t   prev_a_r;
   dpram_pkg::port_req_t   prev_b_r;
   logic [35:0]            prev_rd_a_r;
   logic [35:0]            prev_rd_b_r;
   logic                   live_r;

   // Helper capture of last requests and stored words
   always_ff @(posedge CLK) begin
      prev_a_r    <= req_a;
      prev_b_r    <= req_b;
      prev_rd_a_r <= {rp_a & req_a.pmask, rd_a & req_a.dmask};
      prev_rd_b_r <= {rp_b & req_b.pmask, rd_b & req_b.dmask};
      live_r      <= !RESET;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // Port A read edge last cycle
   sequence s_rd_a;
      live_r && prev_a_r.en && !prev_a_r.rst && !prev_a_r.we;
   endsequence

   // Port A write edge last cycle, no output reset
   sequence s_wr_a;
      live_r && prev_a_r.en && prev_a_r.we && !prev_a_r.rst;
   endsequence

   // Port A write stored with B quiet
   sequence s_wr_a_only;
      live_r && prev_a_r.en && prev_a_r.we &&
      !(prev_b_r.en && prev_b_r.we);
   endsequence

   // Port B write stored with A quiet
   sequence s_wr_b_only;
      live_r && prev_b_r.en && prev_b_r.we &&
      !(prev_a_r.en && prev_a_r.we);
   endsequence

   // Port B read edge last cycle
   sequence s_rd_b;
      live_r && prev_b_r.en && !prev_b_r.rst && !prev_b_r.we;
   endsequence

   // Port B write edge last cycle, no output reset
   sequence s_wr_b;
      live_r && prev_b_r.en && prev_b_r.we && !prev_b_r.rst;
   endsequence

   a_write_stores_a: assert property (
      s_wr_a_only |->
      ((dmem_r[prev_a_r.doff +: 32] & prev_a_r.dmask)
       == prev_a_r.data))
      else $error("Port A write not stored");

   a_write_stores_b: assert property (
      s_wr_b_only |->
      ((dmem_r[prev_b_r.doff +: 32] & prev_b_r.dmask)
       == prev_b_r.data))
      else $error("Port B write not stored");

   a_parity_stored: assert property (
      s_wr_a_only |->
      ((pmem_r[prev_a_r.poff +: 4] & prev_a_r.pmask)
       == prev_a_r.par))
      else $error("Port A parity not stored");

   a_read_loads: assert property (
      s_rd_a |-> (dout_a == prev_rd_a_r))
      else $error("Read did not load stored word");

   a_write_through: assert property (
      ((MODE_A == dpram_pkg::WM_THROUGH) and s_wr_a) |->
      (dout_a == {prev_a_r.par, prev_a_r.data}))
      else $error("Write-through output wrong");

   a_read_before: assert property (
      ((MODE_A == dpram_pkg::WM_READ_FIRST) and s_wr_a) |->
      (dout_a == prev_rd_a_r))
      else $error("Read-first output wrong");

   a_hold_output: assert property (
      ((MODE_A == dpram_pkg::WM_HOLD) and s_wr_a) |->
      $stable(dout_a))
      else $error("Hold mode output changed");

   a_disabled_idle: assert property (
      live_r && !prev_a_r.en |->
      $stable(dout_a) ##1 1'b1)
      else $error("Disabled port changed output");

   a_sync_reset_a: assert property (
      req_a.en && req_a.rst |=> (dout_a == RESET_VAL_A))
      else $error("Port A output reset value wrong");

   a_sync_reset_b: assert property (
      req_b.en && req_b.rst |=> (dout_b == RESET_VAL_B))
      else $error("Port B output reset value wrong");

   a_start_value: assert property (
      $fell(RESET) |->
      (dout_a == START_A) && (dout_b == START_B))
      else $error("Start value missing after reset");

   a_narrow_range: assert property (
      req_a.en |->
      (req_a.doff < 15'(dpram_pkg::DATA_BITS)) &&
      (req_b.doff < 15'(dpram_pkg::DATA_BITS)))
      else $error("Data offset beyond array");

   a_narrow_no_par: assert property (
      (dpram_pkg::pw_of(WIDTH_A) == 0) |->
      (req_a.pmask == 4'h0) && (dout_a[35:32] == 4'h0))
      else $error("Narrow port touched parity");

   a_width_align: assert property (
      req_a.en |->
      ((req_a.doff &
        15'(dpram_pkg::dw_of(WIDTH_A) - 1)) == 15'h0000))
      else $error("Port A offset not word aligned");

   a_read_loads_b: assert property (
      s_rd_b |-> (dout_b == prev_rd_b_r))
      else $error("Port B read did not load stored word");

   a_through_b: assert property (
      ((MODE_B == dpram_pkg::WM_THROUGH) and s_wr_b) |->
      (dout_b == {prev_b_r.par, prev_b_r.data}))
      else $error("Port B write-through output wrong");

   a_read_before_b: assert property (
      ((MODE_B == dpram_pkg::WM_READ_FIRST) and s_wr_b) |->
      (dout_b == prev_rd_b_r))
      else $error("Port B read-first output wrong");

   a_hold_b: assert property (
      ((MODE_B == dpram_pkg::WM_HOLD) and s_wr_b) |->
      $stable(dout_b))
      else $error("Port B hold mode output changed");

   a_idle_b: assert property (
      live_r && !prev_b_r.en |-> $stable(dout_b))
      else $error("Port B disabled but output changed");
endmodule : dual_port_block_ram

// File: verif/fabric_port.sv
// Behavioural fabric logic that drives one memory port
`timescale 1ns/10ps
module fabric_port (
   output logic        en,
   output logic        we,
   output logic        rst,
   output logic [13:0] addr,
   output logic [31:0] data,
   output logic [3:0]  par
);
   // -------------------------------------------------------
   // Start-up levels
   // -------------------------------------------------------
   // All lines quiet before the first request
   initial begin
      en   = 1'h0;
      we   = 1'h0;
      rst  = 1'h0;
      addr = 14'h0000;
      data = 32'h0000_0000;
      par  = 4'h0;
   end

   // -------------------------------------------------------
   // Requests
   // -------------------------------------------------------
   // Request held for one edge
   task automatic drive(input logic e, w, r, input logic [13:0] a,
                        input logic [31:0] d, input logic [3:0] p);
      en   <= e;
      we   <= w;
      rst  <= r;
      addr <= a;
      data <= d;
      par  <= p;
   endtask : drive

   // Idle: strobes low, stale buses inverted each cycle
   task automatic rest;
      en   <= 1'h0;
      we   <= 1'h0;
      rst  <= 1'h0;
      addr <= ~addr;
      data <= ~data;
      par  <= ~par;
   endtask : rest
endmodule : fabric_port

// File: verif/dual_port_block_ram_tb.sv
// Self-checking bench: 36-bit read-first port A, 9-bit through port B
`timescale 1ns/10ps
module dual_port_block_ram_tb;
   // -------------------------------------------------------
   // Configuration and signals
   // -------------------------------------------------------
   localparam logic [35:0] ST_A = 36'h1_2345_6789;  // Start value A
   localparam logic [35:0] RV_A = 36'hE_DCBA_9876;  // Reset value A
   localparam logic [35:0] ST_B = 36'h0_0000_01A5;  // Start value B
   localparam logic [35:0] RV_B = 36'h1_0000_005A;  // Reset value B
   logic        CLK, RESET;
   logic        PORT_A_ENABLE, PORT_A_WRITE_ENABLE, SYNC_OUTPUT_RESET_A;
   logic        PORT_B_ENABLE, PORT_B_WRITE_ENABLE, SYNC_OUTPUT_RESET_B;
   logic [13:0] ADDR_A, ADDR_B;
   logic [31:0] WRITE_DATA_IN_A, WRITE_DATA_IN_B;
   logic [31:0] READ_DATA_OUT_A, READ_DATA_OUT_B;
   logic [3:0]  WRITE_PARITY_IN_A, WRITE_PARITY_IN_B;
   logic [3:0]  READ_PARITY_OUT_A, READ_PARITY_OUT_B;
   logic [31:0] md [0:511];           // Model data words
   logic [3:0]  mp [0:511];           // Model parity words
   logic [35:0] qa[$], qb[$];         // Expected outputs
   logic [35:0] last_a;               // Last expected on A
   logic [31:0] r;                    // Random draw
   logic        chk_a, chk_b;         // Result due at next edge
   int          fail_count, checks_done, seed;

   initial CLK = 1'h0;
   always #5 CLK = ~CLK;

   // -------------------------------------------------------
   // Design and port drivers
   // -------------------------------------------------------
   // Multiplier unused, so 36-bit width is allowed
   dual_port_block_ram #(
      .WIDTH_A(36), .WIDTH_B(9),
      .MODE_A(dpram_pkg::WM_READ_FIRST), .MODE_B(dpram_pkg::WM_THROUGH),
      .START_A(ST_A), .START_B(ST_B), .RESET_VAL_A(RV_A),
      .RESET_VAL_B(RV_B), .MEMORY_CONTENTS_INIT(16384'hA5C3_0F96),
      .PARITY_CONTENTS_INIT(2048'h5), .MULT_IN_USE(1'h0)
   ) dut (
      .CLK(CLK), .RESET(RESET),
      .PORT_A_ENABLE(PORT_A_ENABLE),
      .PORT_A_WRITE_ENABLE(PORT_A_WRITE_ENABLE),
      .SYNC_OUTPUT_RESET_A(SYNC_OUTPUT_RESET_A), .ADDR_A(ADDR_A),
      .WRITE_DATA_IN_A(WRITE_DATA_IN_A),
      .WRITE_PARITY_IN_A(WRITE_PARITY_IN_A),
      .READ_DATA_OUT_A(READ_DATA_OUT_A),
      .READ_PARITY_OUT_A(READ_PARITY_OUT_A),
      .PORT_B_ENABLE(PORT_B_ENABLE),
      .PORT_B_WRITE_ENABLE(PORT_B_WRITE_ENABLE),
      .SYNC_OUTPUT_RESET_B(SYNC_OUTPUT_RESET_B), .ADDR_B(ADDR_B),
      .WRITE_DATA_IN_B(WRITE_DATA_IN_B),
      .WRITE_PARITY_IN_B(WRITE_PARITY_IN_B),
      .READ_DATA_OUT_B(READ_DATA_OUT_B),
      .READ_PARITY_OUT_B(READ_PARITY_OUT_B)
   );
   fabric_port u_a (.en(PORT_A_ENABLE), .we(PORT_A_WRITE_ENABLE),
      .rst(SYNC_OUTPUT_RESET_A), .addr(ADDR_A), .data(WRITE_DATA_IN_A),
      .par(WRITE_PARITY_IN_A));
   fabric_port u_b (.en(PORT_B_ENABLE), .we(PORT_B_WRITE_ENABLE),
      .rst(SYNC_OUTPUT_RESET_B), .addr(ADDR_B), .data(WRITE_DATA_IN_B),
      .par(WRITE_PARITY_IN_B));

   // -------------------------------------------------------
   // Checking
   // -------------------------------------------------------
   task automatic check(input logic [35:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                  seen, exp);
      end
   endtask : check

   task automatic test_done;
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // Watchers take the oldest note once the output has settled
   always @(posedge CLK) begin
      if (chk_a === 1'h1) begin
         #1 check({READ_PARITY_OUT_A, READ_DATA_OUT_A},
                  qa.pop_front());
      end
   end
   always @(posedge CLK) begin
      if (chk_b === 1'h1) begin
         #1 check({27'h0, READ_PARITY_OUT_B[0], READ_DATA_OUT_B[7:0]},
                  qb.pop_front());
      end
   end

   // Outputs equal their start values
   task automatic chk_start;
      #1 check({READ_PARITY_OUT_A, READ_DATA_OUT_A}, ST_A);
      check({27'h0, READ_PARITY_OUT_B[0], READ_DATA_OUT_B[7:0]},
            {27'h0, ST_B[32], ST_B[7:0]});
   endtask : chk_start

   // -------------------------------------------------------
   // Stimulus and model
   // -------------------------------------------------------
   task automatic init_model;
      for (int i = 0; i < 512; i++) begin
         md[i] = 32'h0000_0000;
         mp[i] = 4'h0;
      end
      md[0] = 32'hA5C3_0F96;
      mp[0] = 4'h5;
   endtask : init_model

   // Next edge; both ports fall idle unless a request follows
   task automatic tick;
      @(posedge CLK);
      chk_a <= 1'h0;
      chk_b <= 1'h0;
      u_a.rest();
      u_b.rest();
   endtask : tick

   // Port A request, read-first model
   task automatic op_a(input logic e, w, rs, input logic [8:0] a,
                       input logic [31:0] d, input logic [3:0] p);
      @(posedge CLK);
      chk_b <= 1'h0;
      u_b.rest();
      u_a.drive(e, w, rs, {5'h00, a}, d, p);
      chk_a <= e;
      if (e) begin
         last_a = rs ? RV_A : {mp[a], md[a]};
         if (w) begin
            md[a] = d;
            mp[a] = p;
         end
         qa.push_back(last_a);
      end
   endtask : op_a

   // Port B request, byte n of the shared array, write-through model
   task automatic op_b(input logic e, w, rs, input logic [10:0] n,
                       input logic [7:0] d, input logic p);
      logic [35:0] x;
      @(posedge CLK);
      chk_a <= 1'h0;
      u_a.rest();
      u_b.drive(e, w, rs, {3'h0, n}, {24'h00_0000, d}, {3'h0, p});
      chk_b <= e;
      if (e) begin
         x = {27'h0, mp[n[10:2]][n[1:0]], md[n[10:2]][{n[1:0], 3'h0} +: 8]};
         if (w) begin
            md[n[10:2]][{n[1:0], 3'h0} +: 8] = d;
            mp[n[10:2]][n[1:0]] = p;
            x = {27'h0, p, d};
         end
         if (rs) x = {27'h0, RV_B[32], RV_B[7:0]};
         qb.push_back(x);
      end
   endtask : op_b

   // Watchdog well beyond the expected run
   initial begin
      repeat (3000) @(posedge CLK);
      fail_count++;
      test_done();
   end

   // Main sequence
   initial begin
      seed = 32'h13ED;
      fail_count = 0;
      checks_done = 0;
      chk_a = 1'h0;
      chk_b = 1'h0;
      RESET = 1'h1;
      init_model();
      repeat (8) @(posedge CLK);
      RESET <= 1'h0;
      @(posedge CLK);
      chk_start();
      op_a(1'h1, 1'h0, 1'h0, 9'h000, 32'h0, 4'h0);
      op_b(1'h1, 1'h0, 1'h0, 11'h001, 8'h00, 1'h0);
      op_a(1'h1, 1'h1, 1'h0, 9'h005, $random(seed), 4'h9);
      op_a(1'h1, 1'h0, 1'h0, 9'h005, 32'h0, 4'h0);
      for (int k = 0; k < 4; k++) begin
         op_b(1'h1, 1'h0, 1'h0, {9'h005, 2'(k)}, 8'h00, 1'h0);
      end
      op_b(1'h1, 1'h1, 1'h0, 11'h009, 8'hC4, 1'h1);
      op_a(1'h1, 1'h0, 1'h0, 9'h002, 32'h0, 4'h0);
      op_a(1'h0, 1'h1, 1'h1, 9'h002, 32'hFFFF_FFFF, 4'hF);
      tick();
      #1 check({READ_PARITY_OUT_A, READ_DATA_OUT_A}, last_a);
      op_a(1'h1, 1'h0, 1'h0, 9'h002, 32'h0, 4'h0);
      op_a(1'h1, 1'h1, 1'h1, 9'h003, 32'h6E0D_1234, 4'h3);
      op_a(1'h1, 1'h0, 1'h0, 9'h003, 32'h0, 4'h0);
      op_b(1'h1, 1'h1, 1'h1, 11'h00D, 8'h77, 1'h0);
      // One port at a time, so no same-cell collision
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         if (r[31]) begin
            op_a(1'h1, r[9], 1'h0, r[8:0], $random(seed), r[13:10]);
         end else begin
            op_b(1'h1, r[9], 1'h0, r[20:10], r[28:21], r[29]);
         end
      end
      tick();
      RESET <= 1'h1;
      tick();
      RESET <= 1'h0;
      init_model();
      @(posedge CLK);
      chk_start();
      op_a(1'h1, 1'h0, 1'h0, 9'h005, 32'h0, 4'h0);
      op_b(1'h1, 1'h0, 1'h0, 11'h002, 8'h00, 1'h0);
      tick();
      tick();
      test_done();
   end
endmodule : dual_port_block_ram_tb
